// ==== lcw_codec.sv ====
// Lane control word codec: transmit scheduling and receive recognition
`timescale 1ns/1ps
module lcw_codec
    import lcw_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_send_first,
    input wire logic i_send_second,
    input wire logic i_send_cap,
    input wire logic i_send_standby,
    input lcw_caps_t i_caps,
    input wire logic i_no_signal,
    input wire logic i_err_burst,
    input wire logic i_wake,
    input wire logic i_tx_ready,
    input lcw_word_t i_rx_word,
    input wire logic i_rx_valid,
    output lcw_word_t o_tx_word,
    output logic o_tx_valid,
    output logic o_driver_off,
    output logic o_busy,
    output logic o_rx_first,
    output logic o_rx_second,
    output logic o_rx_inverted,
    output logic o_rx_cap,
    output logic o_rx_standby,
    output logic o_rx_lost,
    output logic o_rx_invert,
    output logic o_flush_vc,
    output lcw_caps_t o_peer_caps,
    output logic o_peer_lost_reason,
    output logic o_lost_suppressed
);

    typedef enum logic [1:0] {
        LCW_TX_IDLE,
        LCW_TX_HOLD,
        LCW_TX_OFF
    } lcw_tx_state_t;

    lcw_tx_state_t state_q;
    lcw_tx_state_t state_d;
    lcw_kind_t kind_q;
    lcw_kind_t pick_kind;
    lcw_word_t built_word;
    lcw_hits_t hits;
    logic pend_first_q;
    logic pend_second_q;
    logic pend_cap_q;
    logic pend_standby_q;
    logic pend_lost_q;
    logic lost_cond_q;
    logic cause_q;
    logic lost_cond;
    logic lost_rise;
    logic load;
    logic accept;
    logic rx_first_any;
    logic rx_second_any;
    logic rx_inv_any;

    // ------------------------------------------------------------
    // Word builder and matcher
    // ------------------------------------------------------------
    lcw_word_build u_build (
        .i_kind(pick_kind),
        .i_caps(i_caps),
        .i_cause(cause_q),
        .o_word(built_word)
    );

    lcw_word_match u_match (
        .i_word(i_rx_word),
        .o_hits(hits)
    );

    // ------------------------------------------------------------
    // Transmit selection
    // ------------------------------------------------------------
    assign lost_cond = i_no_signal | i_err_burst;
    assign lost_rise = lost_cond & ~lost_cond_q;
    assign pick_kind = pend_standby_q ? LCW_W_STANDBY :
        pend_lost_q ? LCW_W_LOST :
        pend_cap_q ? LCW_W_CAP :
        pend_second_q ? LCW_W_SECOND :
        pend_first_q ? LCW_W_FIRST : LCW_W_NONE;
    assign load = (state_q == LCW_TX_IDLE) && (pick_kind != LCW_W_NONE);
    assign accept = (state_q == LCW_TX_HOLD) && i_tx_ready;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            LCW_TX_IDLE:
            begin
                if (load)
                    state_d = LCW_TX_HOLD;
            end
            LCW_TX_HOLD:
            begin
                if (accept)
                    state_d = (kind_q == LCW_W_STANDBY) ?
                        LCW_TX_OFF : LCW_TX_IDLE;
            end
            LCW_TX_OFF:
            begin
                if (i_wake)
                    state_d = LCW_TX_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Pending requests, a new request wins over its clear
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pend_first_q <= 1'b0;
            pend_second_q <= 1'b0;
            pend_cap_q <= 1'b0;
            pend_standby_q <= 1'b0;
        end
        else
        begin
            pend_first_q <= i_send_first
                | (pend_first_q & ~(load & pick_kind == LCW_W_FIRST));
            pend_second_q <= i_send_second
                | (pend_second_q & ~(load & pick_kind == LCW_W_SECOND));
            pend_cap_q <= i_send_cap
                | (pend_cap_q & ~(load & pick_kind == LCW_W_CAP));
            pend_standby_q <= i_send_standby
                | (pend_standby_q & ~(load & pick_kind == LCW_W_STANDBY));
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            lost_cond_q <= 1'b0;
            cause_q <= 1'b0;
            pend_lost_q <= 1'b0;
        end
        else
        begin
            lost_cond_q <= lost_cond;
            if (lost_rise)
                cause_q <= ~i_no_signal;
            pend_lost_q <= ~o_lost_suppressed & ~(i_rx_valid & hits.standby)
                & (lost_rise
                | (pend_lost_q & ~(load & pick_kind == LCW_W_LOST)));
        end
    end

    // ------------------------------------------------------------
    // Transmit word register
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= LCW_TX_IDLE;
            kind_q <= LCW_W_NONE;
            o_tx_word <= '0;
            o_tx_valid <= 1'b0;
            o_driver_off <= 1'b0;
            o_busy <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (load)
            begin
                kind_q <= pick_kind;
                o_tx_word <= built_word;
            end
            o_tx_valid <= (state_d == LCW_TX_HOLD);
            o_driver_off <= (state_d == LCW_TX_OFF);
            o_busy <= (state_d != LCW_TX_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Receive recognition
    // ------------------------------------------------------------
    assign rx_first_any = i_rx_valid & (hits.first | hits.first_inv);
    assign rx_second_any = i_rx_valid & (hits.second | hits.second_inv);
    assign rx_inv_any = i_rx_valid & (hits.first_inv | hits.second_inv);

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rx_first <= 1'b0;
            o_rx_second <= 1'b0;
            o_rx_inverted <= 1'b0;
            o_rx_cap <= 1'b0;
            o_rx_standby <= 1'b0;
            o_rx_lost <= 1'b0;
            o_rx_invert <= LCW_POL_RST;
        end
        else
        begin
            o_rx_first <= rx_first_any;
            o_rx_second <= rx_second_any;
            o_rx_inverted <= rx_inv_any;
            o_rx_cap <= i_rx_valid & hits.cap;
            o_rx_standby <= i_rx_valid & hits.standby;
            o_rx_lost <= i_rx_valid & hits.lost;
            if (rx_inv_any)
                o_rx_invert <= ~o_rx_invert;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_flush_vc <= 1'b0;
            o_peer_caps <= '0;
            o_peer_lost_reason <= 1'b0;
            o_lost_suppressed <= 1'b0;
        end
        else
        begin
            o_flush_vc <= i_rx_valid & hits.cap
                & i_rx_word.d[LCW_SYM_LAST_LSB + LCW_CAP_FLUSH_BIT];
            if (i_rx_valid & hits.cap)
            begin
                o_peer_caps.flush <=
                    i_rx_word.d[LCW_SYM_LAST_LSB + LCW_CAP_FLUSH_BIT];
                o_peer_caps.lane_start <=
                    i_rx_word.d[LCW_SYM_LAST_LSB + LCW_CAP_START_BIT];
                o_peer_caps.scramble <=
                    i_rx_word.d[LCW_SYM_LAST_LSB + LCW_CAP_SCRAMBLE_BIT];
            end
            if (i_rx_valid & hits.lost)
                o_peer_lost_reason <=
                    i_rx_word.d[LCW_SYM_LAST_LSB + LCW_LOST_CAUSE_BIT];
            // Standby wins; far end handshake lifts it
            if (i_rx_valid & hits.standby)
                o_lost_suppressed <= 1'b1;
            else if (rx_first_any)
                o_lost_suppressed <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_comma_low;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_tx_valid |-> (o_tx_word.k == LCW_K_MASK)
            && ((o_tx_word.d[7:0] == LCW_COMMA_INIT)
            || (o_tx_word.d[7:0] == LCW_COMMA));
    endproperty
    a_comma_low: assert property (p_comma_low)
        else $error("Comma not in lowest symbol");

    property p_no_inv_first;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_tx_valid |-> !((o_tx_word.d[15:8] == LCW_ID_INV)
            && (o_tx_word.d[23:16] == LCW_T_FIRST_INV));
    endproperty
    a_no_inv_first: assert property (p_no_inv_first)
        else $error("Inverted first word sent");

    property p_no_inv_second;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_tx_valid |-> (o_tx_word.d[15:8] == LCW_ID)
            && (o_tx_word.d[23:16] != LCW_T_SECOND_INV);
    endproperty
    a_no_inv_second: assert property (p_no_inv_second)
        else $error("Inverted second word sent");

    property p_first_word;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state_q == LCW_TX_IDLE && pick_kind == LCW_W_FIRST)
            |=> o_tx_valid && o_tx_word.d == 32'h4646cebc;
    endproperty
    a_first_word: assert property (p_first_word)
        else $error("First handshake word wrong");

    property p_second_word;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (load && pick_kind == LCW_W_SECOND)
            |=> o_tx_word.d == 32'ha6a6cebc;
    endproperty
    a_second_word: assert property (p_second_word)
        else $error("Second handshake word wrong");

    property p_cap_word;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (load && pick_kind == LCW_W_CAP) |=> o_tx_word.d[23:0] == 24'h38cebc
            && (o_tx_word.d[31:24] & LCW_CAP_RSVD_MASK) == 8'h00
            && o_tx_word.d[24] == $past(i_caps.flush);
    endproperty
    a_cap_word: assert property (p_cap_word)
        else $error("Capability word wrong");

    property p_standby_off;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (o_tx_valid && o_tx_word.d == 32'h7e7ecefc && i_tx_ready)
            |=> o_driver_off && !o_tx_valid;
    endproperty
    a_standby_off: assert property (p_standby_off)
        else $error("Driver not off after standby word");

    property p_lost_send;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        ($rose(lost_cond) && !o_lost_suppressed && !pend_standby_q
            && state_q == LCW_TX_IDLE && !i_rx_valid)
            |-> ##[1:2] (o_tx_valid && o_tx_word.d[23:0] == 24'h64cefc
            && o_tx_word.d[31:24] == {7'h00, $past(i_err_burst, 2)
            & ~$past(i_no_signal, 2)});
    endproperty
    a_lost_send: assert property (p_lost_send)
        else $error("Signal lost word not sent");

    property p_lost_quiet;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_lost_suppressed |-> !pend_lost_q;
    endproperty
    a_lost_quiet: assert property (p_lost_quiet)
        else $error("Signal lost pending while suppressed");

    property p_inv_flip;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_rx_valid && (hits.first_inv || hits.second_inv))
            |=> o_rx_inverted && o_rx_invert != $past(o_rx_invert);
    endproperty
    a_inv_flip: assert property (p_inv_flip)
        else $error("Polarity not flipped");

    property p_flush;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_rx_valid && hits.cap)
            |=> o_rx_cap && o_flush_vc == $past(i_rx_word.d[24])
            && o_peer_caps.lane_start == $past(i_rx_word.d[25])
            && o_peer_caps.scramble == $past(i_rx_word.d[26]);
    endproperty
    a_flush: assert property (p_flush)
        else $error("Capability fields not taken");

endmodule : lcw_codec

// ==== lcw_pkg.sv ====
// Package: symbol codes, field positions and carrier types of the codec
package lcw_pkg;

    // ------------------------------------------------------------
    // Symbol codes (Dx.y = y in [7:5], x in [4:0])
    // ------------------------------------------------------------
    localparam logic [7:0] LCW_COMMA_INIT = 8'hbc;
    localparam logic [7:0] LCW_COMMA = 8'hfc;
    localparam logic [7:0] LCW_ID = 8'hce;
    localparam logic [7:0] LCW_ID_INV = 8'h31;
    localparam logic [7:0] LCW_T_FIRST = 8'h46;
    localparam logic [7:0] LCW_T_FIRST_INV = 8'hb9;
    localparam logic [7:0] LCW_T_SECOND = 8'ha6;
    localparam logic [7:0] LCW_T_SECOND_INV = 8'h59;
    localparam logic [7:0] LCW_T_CAP = 8'h38;
    localparam logic [7:0] LCW_T_STANDBY = 8'h7e;
    localparam logic [7:0] LCW_T_LOST = 8'h64;
    localparam logic [3:0] LCW_K_MASK = 4'h1;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned LCW_CAP_FLUSH_BIT = 0;
    localparam int unsigned LCW_CAP_START_BIT = 1;
    localparam int unsigned LCW_CAP_SCRAMBLE_BIT = 2;
    localparam int unsigned LCW_LOST_CAUSE_BIT = 0;
    localparam int unsigned LCW_SYM_TYPE_LSB = 16;
    localparam int unsigned LCW_SYM_LAST_LSB = 24;
    localparam logic LCW_POL_RST = 1'b0;
    localparam logic [7:0] LCW_CAP_RSVD_MASK = 8'hf8;
    localparam logic [7:0] LCW_LOST_RSVD_MASK = 8'hfe;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] k;
        logic [31:0] d;
    } lcw_word_t;

    typedef struct packed {
        logic scramble;
        logic lane_start;
        logic flush;
    } lcw_caps_t;

    typedef struct packed {
        logic first;
        logic first_inv;
        logic second;
        logic second_inv;
        logic cap;
        logic standby;
        logic lost;
    } lcw_hits_t;

    typedef enum logic [2:0] {
        LCW_W_NONE,
        LCW_W_FIRST,
        LCW_W_SECOND,
        LCW_W_CAP,
        LCW_W_STANDBY,
        LCW_W_LOST
    } lcw_kind_t;

    // ------------------------------------------------------------
    // Word helpers
    // ------------------------------------------------------------
    function automatic lcw_word_t lcw_pack(input logic [7:0] comma,
        input logic [7:0] id, input logic [7:0] typ, input logic [7:0] last);
        lcw_word_t w;
        w.k = LCW_K_MASK;
        w.d = {last, typ, id, comma};
        return w;
    endfunction : lcw_pack

    function automatic logic lcw_match(input lcw_word_t w,
        input logic [7:0] comma, input logic [7:0] id, input logic [7:0] typ);
        return (w.k == LCW_K_MASK) && (w.d[7:0] == comma)
            && (w.d[15:8] == id) && (w.d[23:16] == typ);
    endfunction : lcw_match

    function automatic logic lcw_match_copy(input lcw_word_t w,
        input logic [7:0] comma, input logic [7:0] id, input logic [7:0] typ);
        return lcw_match(w, comma, id, typ) && (w.d[31:24] == typ);
    endfunction : lcw_match_copy

endpackage : lcw_pkg

// ==== lcw_word_build.sv ====
// Transmit word builder: kind plus fields to a four-symbol word
`timescale 1ns/1ps
module lcw_word_build
    import lcw_pkg::*;
(
    input lcw_kind_t i_kind,
    input lcw_caps_t i_caps,
    input wire logic i_cause,
    output lcw_word_t o_word
);

    logic [7:0] cap_byte;
    logic [7:0] cause_byte;

    // ------------------------------------------------------------
    // Field bytes, reserved bits zero
    // ------------------------------------------------------------
    assign cap_byte = ({7'h00, i_caps.flush} << LCW_CAP_FLUSH_BIT)
        | ({7'h00, i_caps.lane_start} << LCW_CAP_START_BIT)
        | ({7'h00, i_caps.scramble} << LCW_CAP_SCRAMBLE_BIT);
    assign cause_byte = {7'h00, i_cause} << LCW_LOST_CAUSE_BIT;

    // ------------------------------------------------------------
    // Word select, inverted forms never built
    // ------------------------------------------------------------
    assign o_word = (i_kind == LCW_W_FIRST) ?
            lcw_pack(LCW_COMMA_INIT, LCW_ID, LCW_T_FIRST, LCW_T_FIRST) :
        (i_kind == LCW_W_SECOND) ?
            lcw_pack(LCW_COMMA_INIT, LCW_ID, LCW_T_SECOND, LCW_T_SECOND) :
        (i_kind == LCW_W_CAP) ?
            lcw_pack(LCW_COMMA_INIT, LCW_ID, LCW_T_CAP, cap_byte) :
        (i_kind == LCW_W_STANDBY) ?
            lcw_pack(LCW_COMMA, LCW_ID, LCW_T_STANDBY, LCW_T_STANDBY) :
        (i_kind == LCW_W_LOST) ?
            lcw_pack(LCW_COMMA, LCW_ID, LCW_T_LOST, cause_byte) :
            '0;

endmodule : lcw_word_build

// ==== lcw_word_match.sv ====
// Receive word matcher: flags which control word is present
`timescale 1ns/1ps
module lcw_word_match
    import lcw_pkg::*;
(
    input lcw_word_t i_word,
    output lcw_hits_t o_hits
);

    // ------------------------------------------------------------
    // Comma in symbol 0, identifier, type, fourth symbol
    // ------------------------------------------------------------
    assign o_hits.first = lcw_match_copy(i_word, LCW_COMMA_INIT, LCW_ID,
        LCW_T_FIRST);
    assign o_hits.first_inv = lcw_match_copy(i_word, LCW_COMMA_INIT,
        LCW_ID_INV, LCW_T_FIRST_INV);
    assign o_hits.second = lcw_match_copy(i_word, LCW_COMMA_INIT, LCW_ID,
        LCW_T_SECOND);
    assign o_hits.second_inv = lcw_match_copy(i_word, LCW_COMMA_INIT,
        LCW_ID_INV, LCW_T_SECOND_INV);
    // Cap and lost: fourth symbol free; standby: fourth symbol copies type; no inverted form checked
    assign o_hits.cap = lcw_match(i_word, LCW_COMMA_INIT, LCW_ID,
        LCW_T_CAP);
    assign o_hits.standby = lcw_match_copy(i_word, LCW_COMMA, LCW_ID,
        LCW_T_STANDBY);
    assign o_hits.lost = lcw_match(i_word, LCW_COMMA, LCW_ID,
        LCW_T_LOST);

endmodule : lcw_word_match

// ==== lcw_peer.sv ====
// Peer lane interface model: takes transmit words, sends receive words
`timescale 1ns/1ps
module lcw_peer
    import lcw_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_slow,
    input lcw_word_t i_tx_word,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output lcw_word_t o_rx_word,
    output logic o_rx_valid,
    output lcw_word_t o_got,
    output int o_got_n
);
    int wait_cnt;
    initial
    begin
        o_tx_ready = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_word = '0;
        o_got = '0;
        o_got_n = 0;
        wait_cnt = 0;
    end
    // ------------------------------------------------------------
    // Take words, slowly when asked
    // ------------------------------------------------------------
    always @(negedge i_ref_clk)
    begin
        wait_cnt <= i_tx_valid ? wait_cnt + 1 : 0;
        o_tx_ready <= i_tx_valid && (!i_slow || wait_cnt >= 2);
    end
    always @(posedge i_ref_clk)
    begin
        if (i_tx_valid && o_tx_ready)
        begin
            o_got <= i_tx_word;
            o_got_n <= o_got_n + 1;
        end
    end
    // ------------------------------------------------------------
    // Send one word, comma in lowest symbol; line inverted after
    // ------------------------------------------------------------
    task automatic send(input lcw_word_t w);
        @(negedge i_ref_clk);
        o_rx_word = w;
        o_rx_valid = 1'b1;
        @(negedge i_ref_clk);
        o_rx_valid = 1'b0;
        o_rx_word = ~w;
    endtask : send
endmodule : lcw_peer

// ==== tb.sv ====
// Testbench: codec against peer model, transmit and receive scenarios
`timescale 1ns/1ps
module tb;
    import lcw_pkg::*;
    logic clk = 1'b0;
    logic nrst;
    logic s1, s2, s3, ssb;
    logic nosig, errb, wake, slow;
    lcw_caps_t caps;
    lcw_word_t tx_word, rx_word, got;
    logic tx_valid, tx_ready, rx_valid, drv_off, busy, r_first, r_second;
    logic r_inv, r_cap, r_sb, r_lost, r_invert, flush, reason, supp;
    lcw_caps_t pcaps;
    int got_n;
    int mismatches = 0;
    int comparisons = 0;
    always #12.5 clk = ~clk;
    lcw_codec u_lcw_codec (.i_ref_clk(clk), .i_nrst(nrst),
        .i_send_first(s1), .i_send_second(s2), .i_send_cap(s3),
        .i_send_standby(ssb), .i_caps(caps), .i_no_signal(nosig),
        .i_err_burst(errb), .i_wake(wake), .i_tx_ready(tx_ready),
        .i_rx_word(rx_word), .i_rx_valid(rx_valid), .o_tx_word(tx_word),
        .o_tx_valid(tx_valid), .o_driver_off(drv_off), .o_busy(busy),
        .o_rx_first(r_first), .o_rx_second(r_second),
        .o_rx_inverted(r_inv), .o_rx_cap(r_cap), .o_rx_standby(r_sb),
        .o_rx_lost(r_lost), .o_rx_invert(r_invert), .o_flush_vc(flush),
        .o_peer_caps(pcaps), .o_peer_lost_reason(reason),
        .o_lost_suppressed(supp));
    lcw_peer u_lcw_peer (.i_ref_clk(clk), .i_slow(slow),
        .i_tx_word(tx_word), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
        .o_rx_word(rx_word), .o_rx_valid(rx_valid), .o_got(got),
        .o_got_n(got_n));
    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_word(input lcw_word_t g, input lcw_word_t e);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_bits(input logic [2:0] g, input logic [2:0] e);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_bits
    task automatic wrap_up;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // Request a word (index 4 = none) and check what the peer took
    task automatic tx_expect(input int which, input lcw_word_t e);
        int n0;
        n0 = got_n;
        @(negedge clk);
        {ssb, s3, s2, s1} = 4'(1 << which);
        @(negedge clk);
        {ssb, s3, s2, s1} = 4'h0;
        repeat (20) if (got_n == n0) @(negedge clk);
        chk_word(got, e);
    endtask : tx_expect
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_tx_words;
        chk_bits({drv_off, supp, r_invert}, 3'h0);
        tx_expect(0, 36'h1_4646cebc);
        tx_expect(1, 36'h1_a6a6cebc);
        slow = 1'b1;
        caps = 3'h7;
        tx_expect(2, 36'h1_0738cebc);
        caps = 3'h2;
        tx_expect(2, 36'h1_0238cebc);
        slow = 1'b0;
    endtask : t_tx_words
    task automatic t_tx_standby_lost;
        tx_expect(3, 36'h1_7e7ecefc);
        chk_bits({drv_off, tx_valid, busy}, 3'h5);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        @(negedge clk);
        chk_bits({drv_off, busy, 1'b0}, 3'h0);
        nosig = 1'b1;
        tx_expect(4, 36'h1_0064cefc);
        nosig = 1'b0;
        @(negedge clk);
        errb = 1'b1;
        tx_expect(4, 36'h1_0164cefc);
        errb = 1'b0;
    endtask : t_tx_standby_lost
    task automatic t_rx_handshake;
        u_lcw_peer.send(36'h1_b9b931bc);
        chk_bits({r_first, r_inv, r_invert}, 3'h7);
        u_lcw_peer.send(36'h1_595931bc);
        chk_bits({r_second, r_inv, r_invert}, 3'h6);
        u_lcw_peer.send(36'h1_4646cebc);
        chk_bits({r_first, r_inv, r_second}, 3'h4);
        u_lcw_peer.send(36'h1_a6a6cebc);
        chk_bits({r_second, r_inv, r_first}, 3'h4);
    endtask : t_rx_handshake
    task automatic t_rx_caps;
        u_lcw_peer.send(36'h1_ff38cebc);
        chk_bits({r_cap, flush, 1'b0}, 3'h6);
        chk_bits(pcaps, 3'h7);
        u_lcw_peer.send(36'h1_fa38cebc);
        chk_bits({r_cap, flush, 1'b0}, 3'h4);
        chk_bits(pcaps, 3'h2);
        u_lcw_peer.send(36'h1_ff39cebc);
        chk_bits({r_cap, flush, 1'b0}, 3'h0);
    endtask : t_rx_caps
    task automatic t_rx_lost_standby;
        int n0;
        u_lcw_peer.send(36'h1_ff64cefc);
        chk_bits({r_lost, reason, supp}, 3'h6);
        u_lcw_peer.send(36'h1_fe64cefc);
        chk_bits({r_lost, reason, supp}, 3'h4);
        u_lcw_peer.send(36'h1_7e7ecefc);
        chk_bits({r_sb, supp, 1'b0}, 3'h6);
        n0 = got_n;
        nosig = 1'b1;
        repeat (10) @(negedge clk);
        chk_bits(3'(got_n - n0), 3'h0);
        nosig = 1'b0;
        u_lcw_peer.send(36'h1_4646cebc);
        chk_bits({r_first, supp, 1'b0}, 3'h4);
    endtask : t_rx_lost_standby
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        {nrst, s1, s2, s3, ssb, nosig, errb, wake, slow} = 9'h000;
        caps = 3'h0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        t_tx_words();
        t_tx_standby_lost();
        t_rx_handshake();
        t_rx_caps();
        t_rx_lost_standby();
        wrap_up();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule : tb
